// >>> rtl/spx_pkg.sv
package spx_pkg;

  // register offsets on the 3-bit byte-wide register port
  localparam logic [2:0] SPX_OFS_CTRL1 = 3'h0;
  localparam logic [2:0] SPX_OFS_CTRL2 = 3'h1;
  localparam logic [2:0] SPX_OFS_RATE = 3'h2;
  localparam logic [2:0] SPX_OFS_STAT = 3'h3;
  localparam logic [2:0] SPX_OFS_DATA_HI = 3'h4;
  localparam logic [2:0] SPX_OFS_DATA_LO = 3'h5;
  localparam logic [2:0] SPX_OFS_MATCH_HI = 3'h6;
  localparam logic [2:0] SPX_OFS_MATCH_LO = 3'h7;

  // first control register layout
  typedef struct packed {
    logic irq_en;
    logic enable;
    logic tx_irq_en;
    logic master_select_bit;
    logic cpol;
    logic cpha;
    logic select_output_enable;
    logic lsb_first;
  } spx_ctrl1_t;

  // second_control_register layout
  typedef struct packed {
    logic match_irq_en;
    logic word_length_bit;
    logic rsv5;
    logic mode_fault_enable;
    logic bidir_oe;
    logic rsv2;
    logic stop_in_wait_bit;
    logic bidirectional_select_bit;
  } spx_ctrl2_t;

  // reset values and writable-bit masks
  localparam logic [7:0] SPX_CTRL1_RST = 8'h04;
  localparam logic [7:0] SPX_CTRL2_RST = 8'h00;
  localparam logic [7:0] SPX_RATE_RST = 8'h00;
  localparam logic [7:0] SPX_CTRL2_WMASK = 8'hdb;
  localparam logic [7:0] SPX_RATE_WMASK = 8'h77;

  // rate register fields
  localparam int SPX_PRESCALE_LSB = 4;
  localparam int SPX_RATE_LSB = 0;

  // status bit positions
  localparam int SPX_ST_RX_FULL = 7;
  localparam int SPX_ST_MATCH = 6;
  localparam int SPX_ST_TX_EMPTY = 5;
  localparam int SPX_ST_MODE_FAULT = 4;

  // index of the last clock edge of a word (two edges per bit)
  localparam logic [4:0] SPX_LAST_EDGE_8 = 5'h0f;
  localparam logic [4:0] SPX_LAST_EDGE_16 = 5'h1f;

  typedef enum {SPX_IDLE, SPX_RUN} spx_state_t;

endpackage

// >>> rtl/spx_spi16.sv
// Functional notes
// - wait with stop-in-wait clear: block runs as in run mode.
// - wait with stop-in-wait set: clock generation stops, master pauses then resumes.
// - a slave keeps shifting its current word during wait.
// - stop3: master halts and resumes later; slave keeps shifting with master.
// - deeper stop: block disabled and all registers return to reset values.
// - only master starts transfers; both shift registers swap contents.
// - slave works only while its select input is low.
// - written word waits in transmit buffer, loaded into shifter at start.
// - after 8 or 16 bits the received word goes to receive buffer.
// - master drives serial clock and MOSI, samples MISO.
// - slave takes clock from pin, drives MISO, samples MOSI.
// - bit rate is bus clock over (prescale+1) times 2^(rate+1).
// - automatic select output is low during transfers, high while idle.
// - automatic select only as master with select-output and fault enables set.
// - automatic select output disables mode-fault detection.
// - bidirectional select makes the block use one data pin.
// - bidirectional: master uses MOSI, slave uses MISO, other pin unused.
// - software picks MSB-first or LSB-first shifting.
// - mode fault sets a flag that can raise an interrupt.
// - clock polarity and phase select idle level and sample edges.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
module spx_spi16 (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_wait,
  input wire logic i_stop3,
  input wire logic i_stop_deep,
  output logic o_irq,
  input wire logic i_sclk,
  output logic o_sclk,
  output logic o_sclk_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_ss_b,
  output logic o_ss_b,
  output logic o_ss_oe
);

  // half a serial clock period in bus cycles: (prescale+1) * 2^rate
  function automatic logic [10:0] half_period(input logic [2:0] pre, input logic [2:0] rate);
    logic [10:0] base;
    base = {8'h00, pre} + 11'h001;
    return base << rate;
  endfunction

  // bit that currently sits at the output end of the shifter
  function automatic logic out_bit(input logic [15:0] sh, input logic w16, input logic lsb);
    return lsb ? sh[0] : (w16 ? sh[15] : sh[7]);
  endfunction

  // shift one bit in at the input end, keeping unused upper bits clear in 8-bit mode
  function automatic logic [15:0] shift_in(input logic [15:0] sh, input logic b,
                                           input logic w16, input logic lsb);
    logic [15:0] r;
    r = 16'h0000;
    if (lsb) begin
      r = {1'b0, sh[15:1]};
      if (w16) begin
        r[15] = b;
      end else begin
        r[7] = b;
        r[15:8] = 8'h00;
      end
    end else begin
      r = {sh[14:0], b};
      if (!w16) begin
        r[15:8] = 8'h00;
      end
    end
    return r;
  endfunction

  spx_pkg::spx_ctrl1_t ctrl1_r;
  spx_pkg::spx_ctrl2_t ctrl2_r;
  logic [7:0] rate_r;
  logic [15:0] tx_r;
  logic tx_full_r;
  logic [15:0] rx_r;
  logic rx_full_r;
  logic [15:0] match_r;
  logic match_flag_r;
  logic mode_fault_r;
  spx_pkg::spx_state_t state_r;
  logic tail_r;
  logic [10:0] div_cnt_r;
  logic [4:0] edge_cnt_r;
  logic [15:0] shift_r;
  logic out_r;
  logic sclk_r;
  logic sclk_prev_r;
  logic [7:0] rdata_r;

  logic enabled;
  logic is_master;
  logic w16;
  logic bidir;
  logic halt;
  logic auto_select;
  logic mode_fault_evt;
  logic slave_sel;
  logic running;
  logic master_edge;
  logic slave_edge;
  logic clk_edge;
  logic sample;
  logic change;
  logic done;
  logic start;
  logic abort;
  logic ser_in;
  logic [4:0] last_edge;
  logic [10:0] half;
  logic [15:0] shift_nxt;
  logic [15:0] tx_word;
  logic [7:0] stat;
  logic wr_data_lo;
  logic rd_data_lo;
  logic rx_equal;

  assign enabled = ctrl1_r.enable;
  assign is_master = ctrl1_r.master_select_bit;
  assign w16 = ctrl2_r.word_length_bit;
  assign bidir = ctrl2_r.bidirectional_select_bit;
  assign running = (state_r == spx_pkg::SPX_RUN);
  assign last_edge = w16 ? spx_pkg::SPX_LAST_EDGE_16 : spx_pkg::SPX_LAST_EDGE_8;
  assign half = half_period(rate_r[spx_pkg::SPX_PRESCALE_LSB +: 3],
                            rate_r[spx_pkg::SPX_RATE_LSB +: 3]);

  // only a master stalls; a slave follows the outside clock through wait and stop3
  assign halt = is_master & ((i_wait & ctrl2_r.stop_in_wait_bit) | i_stop3);

  // automatic select needs master plus both enables, and then masks fault detection
  assign auto_select = is_master & ctrl1_r.select_output_enable
                     & ctrl2_r.mode_fault_enable;
  assign mode_fault_evt = enabled & is_master & ctrl2_r.mode_fault_enable
                        & !ctrl1_r.select_output_enable & !i_ss_b;

  assign slave_sel = enabled & !is_master & !i_ss_b;

  // shifter input pin depends on role and on single-wire mode
  always_comb begin
    if (bidir) begin
      ser_in = is_master ? i_mosi : i_miso;
    end else begin
      ser_in = is_master ? i_miso : i_mosi;
    end
  end

  // clock edges: generated for a master, taken from the pin for a slave
  assign master_edge = running & is_master & !halt & (div_cnt_r == half - 11'h001);
  assign slave_edge = running & slave_sel & (i_sclk != sclk_prev_r);
  assign clk_edge = is_master ? master_edge : slave_edge;
  assign sample = clk_edge & (edge_cnt_r[0] == ctrl1_r.cpha);
  assign change = clk_edge & !sample;
  assign done = clk_edge & (edge_cnt_r == last_edge);
  assign shift_nxt = sample ? shift_in(shift_r, ser_in, w16, ctrl1_r.lsb_first) : shift_r;

  // transfers start only from a master with data, or a selected slave
  assign start = !running & !i_stop_deep
               & ((enabled & is_master & !halt & tx_full_r & !mode_fault_evt & !tail_r)
                  | slave_sel);
  assign abort = running & (!enabled | i_stop_deep
                 | (is_master ? mode_fault_evt : i_ss_b));
  assign tx_word = w16 ? tx_r : {8'h00, tx_r[7:0]};

  assign wr_data_lo = i_wr & (i_addr == spx_pkg::SPX_OFS_DATA_LO);
  assign rd_data_lo = i_rd & (i_addr == spx_pkg::SPX_OFS_DATA_LO);
  assign rx_equal = w16 ? (shift_nxt == match_r) : (shift_nxt[7:0] == match_r[7:0]);

  // control registers; a deep stop puts them back to reset values
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl1_r <= spx_pkg::SPX_CTRL1_RST;
      ctrl2_r <= spx_pkg::SPX_CTRL2_RST;
      rate_r <= spx_pkg::SPX_RATE_RST;
      match_r <= 16'h0000;
    end else if (i_stop_deep) begin
      ctrl1_r <= spx_pkg::SPX_CTRL1_RST;
      ctrl2_r <= spx_pkg::SPX_CTRL2_RST;
      rate_r <= spx_pkg::SPX_RATE_RST;
      match_r <= 16'h0000;
    end else if (i_wr) begin
      unique case (i_addr)
        spx_pkg::SPX_OFS_CTRL1: ctrl1_r <= i_wdata;
        spx_pkg::SPX_OFS_CTRL2: ctrl2_r <= i_wdata & spx_pkg::SPX_CTRL2_WMASK;
        spx_pkg::SPX_OFS_RATE: rate_r <= i_wdata & spx_pkg::SPX_RATE_WMASK;
        spx_pkg::SPX_OFS_MATCH_HI: match_r[15:8] <= i_wdata;
        spx_pkg::SPX_OFS_MATCH_LO: match_r[7:0] <= i_wdata;
        default: ;
      endcase
    end
  end

  // transmit buffer: low byte write arms it, transfer start empties it
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_r <= 16'h0000;
      tx_full_r <= 1'b0;
    end else if (i_stop_deep) begin
      tx_r <= 16'h0000;
      tx_full_r <= 1'b0;
    end else begin
      if (i_wr && i_addr == spx_pkg::SPX_OFS_DATA_HI) begin
        tx_r[15:8] <= i_wdata;
      end
      if (wr_data_lo) begin
        tx_r[7:0] <= i_wdata;
        tx_full_r <= 1'b1;
      end else if (start) begin
        tx_full_r <= 1'b0;
      end
    end
  end

  // receive buffer and its flags; a new word wins over a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_r <= 16'h0000;
      rx_full_r <= 1'b0;
      match_flag_r <= 1'b0;
    end else if (i_stop_deep) begin
      rx_r <= 16'h0000;
      rx_full_r <= 1'b0;
      match_flag_r <= 1'b0;
    end else begin
      if (done) begin
        rx_r <= shift_nxt;
        rx_full_r <= 1'b1;
      end else if (rd_data_lo) begin
        rx_full_r <= 1'b0;
      end
      if (done && rx_equal) begin
        match_flag_r <= 1'b1;
      end else if (i_wr && i_addr == spx_pkg::SPX_OFS_STAT && i_wdata[spx_pkg::SPX_ST_MATCH]) begin
        match_flag_r <= 1'b0;
      end
    end
  end

  // mode fault: set by the select pin, cleared by writing one to its status bit
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_fault_r <= 1'b0;
    end else if (i_stop_deep) begin
      mode_fault_r <= 1'b0;
    end else if (mode_fault_evt) begin
      mode_fault_r <= 1'b1;
    end else if (i_wr && i_addr == spx_pkg::SPX_OFS_STAT
                 && i_wdata[spx_pkg::SPX_ST_MODE_FAULT]) begin
      mode_fault_r <= 1'b0;
    end
  end

  // transfer state; select stays low one cycle past the last clock edge of a word
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= spx_pkg::SPX_IDLE;
      tail_r <= 1'b0;
    end else begin
      tail_r <= done & !abort;
      unique case (state_r)
        spx_pkg::SPX_IDLE: if (start) state_r <= spx_pkg::SPX_RUN;
        spx_pkg::SPX_RUN: if (abort || done) state_r <= spx_pkg::SPX_IDLE;
      endcase
    end
  end

  // bit-rate divider; it simply holds while halted, so a paused word resumes intact
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_cnt_r <= 11'h000;
    end else if (start || master_edge || !running) begin
      div_cnt_r <= 11'h000;
    end else if (is_master && !halt) begin
      div_cnt_r <= div_cnt_r + 11'h001;
    end
  end

  // edge counter: two edges per bit
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      edge_cnt_r <= 5'h00;
    end else if (start) begin
      edge_cnt_r <= 5'h00;
    end else if (clk_edge) begin
      edge_cnt_r <= edge_cnt_r + 5'h01;
    end
  end

  // shifter: loaded from the buffer at start, shifts on sampling edges
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shift_r <= 16'h0000;
    end else if (start) begin
      shift_r <= tx_word;
    end else if (sample) begin
      shift_r <= shift_nxt;
    end
  end

  // output bit changes on the non-sampling edge so it is stable when sampled
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_r <= 1'b0;
    end else if (start) begin
      out_r <= out_bit(tx_word, w16, ctrl1_r.lsb_first);
    end else if (change) begin
      out_r <= out_bit(shift_r, w16, ctrl1_r.lsb_first);
    end
  end

  // generated serial clock; rests at the polarity level between words
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_r <= 1'b0;
    end else if (!running) begin
      sclk_r <= ctrl1_r.cpol;
    end else if (master_edge) begin
      sclk_r <= !sclk_r;
    end
  end

  // previous pin level for slave edge detection
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= i_sclk;
    end
  end

  // status byte; reserved bits read zero
  always_comb begin
    stat = 8'h00;
    stat[spx_pkg::SPX_ST_RX_FULL] = rx_full_r;
    stat[spx_pkg::SPX_ST_MATCH] = match_flag_r;
    stat[spx_pkg::SPX_ST_TX_EMPTY] = !tx_full_r;
    stat[spx_pkg::SPX_ST_MODE_FAULT] = mode_fault_r;
  end

  // read data appears only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_r <= 8'h00;
    end else if (i_rd) begin
      unique case (i_addr)
        spx_pkg::SPX_OFS_CTRL1: rdata_r <= ctrl1_r;
        spx_pkg::SPX_OFS_CTRL2: rdata_r <= ctrl2_r;
        spx_pkg::SPX_OFS_RATE: rdata_r <= rate_r;
        spx_pkg::SPX_OFS_STAT: rdata_r <= stat;
        spx_pkg::SPX_OFS_DATA_HI: rdata_r <= rx_r[15:8];
        spx_pkg::SPX_OFS_DATA_LO: rdata_r <= rx_r[7:0];
        spx_pkg::SPX_OFS_MATCH_HI: rdata_r <= match_r[15:8];
        spx_pkg::SPX_OFS_MATCH_LO: rdata_r <= match_r[7:0];
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign o_rdata = rdata_r;

  // interrupt request is a level while any enabled flag stands
  assign o_irq = (ctrl1_r.irq_en & (rx_full_r | mode_fault_r))
               | (ctrl1_r.tx_irq_en & !tx_full_r)
               | (ctrl2_r.match_irq_en & match_flag_r);

  // pin drivers; in single-wire mode the direction bit steers the shared pin
  assign o_sclk = sclk_r;
  assign o_sclk_oe = enabled & is_master;
  assign o_mosi = out_r;
  assign o_mosi_oe = enabled & is_master & (!bidir | ctrl2_r.bidir_oe);
  assign o_miso = out_r;
  assign o_miso_oe = slave_sel & (!bidir | ctrl2_r.bidir_oe);
  assign o_ss_b = !(running | tail_r);
  assign o_ss_oe = enabled & auto_select;

endmodule

// >>> tb/spx_spi16_monitor.sv
module spx_spi16_monitor (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_wait,
  input wire logic i_stop3,
  input wire logic i_stop_deep,
  input wire logic o_sclk,
  input wire logic o_sclk_oe,
  input wire logic o_miso_oe,
  input wire logic i_ss_b,
  input wire logic o_ss_b,
  input wire logic o_ss_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  spx_pkg::spx_ctrl1_t c1_r;
  spx_pkg::spx_ctrl2_t c2_r;
  logic mst;

  // shadow of the control registers; only ports are visible here
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      c1_r <= spx_pkg::SPX_CTRL1_RST;
      c2_r <= spx_pkg::SPX_CTRL2_RST;
    end else if (i_stop_deep) begin
      c1_r <= spx_pkg::SPX_CTRL1_RST;
      c2_r <= spx_pkg::SPX_CTRL2_RST;
    end else if (i_wr && i_addr == spx_pkg::SPX_OFS_CTRL1) begin
      c1_r <= i_wdata;
    end else if (i_wr && i_addr == spx_pkg::SPX_OFS_CTRL2) begin
      c2_r <= i_wdata & spx_pkg::SPX_CTRL2_WMASK;
    end
  end

  // enabled master
  assign mst = c1_r.enable && c1_r.master_select_bit;

  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  a_master_clk_out: assert property (mst |-> o_sclk_oe)
    else $error("master does not drive the serial clock");
  a_slave_clk_in: assert property (!c1_r.master_select_bit |-> !o_sclk_oe)
    else $error("slave drives the serial clock");
  a_auto_sel_gate: assert property (o_ss_oe == (mst && c1_r.select_output_enable
    && c2_r.mode_fault_enable)) else $error("select output enable mismatch");
  // two cycles of slack after a write, since a polarity change moves an idle clock
  a_sel_low_xfer: assert property ((o_ss_oe && $changed(o_sclk) && !$past(i_wr)
    && !$past(i_wr, 2)) |-> !o_ss_b) else $error("clock toggles with select high");
  a_wait_freeze: assert property ((mst && c2_r.stop_in_wait_bit && i_wait
    && $past(i_wait) && $past(i_wait, 2)) |-> $stable(o_sclk))
    else $error("serial clock runs in wait with stop bit set");
  a_stop3_freeze: assert property ((mst && i_stop3 && $past(i_stop3)
    && $past(i_stop3, 2)) |-> $stable(o_sclk)) else $error("serial clock runs in stop3");
  a_bidir_one_pin: assert property ((mst && c2_r.bidirectional_select_bit)
    |-> !o_miso_oe) else $error("master drives the unused data pin");
  a_slave_unsel: assert property ((!c1_r.master_select_bit && i_ss_b && $past(i_ss_b))
    |-> !o_miso_oe) else $error("unselected slave drives its data pin");
  a_deep_off: assert property ($past(i_stop_deep) |-> (!o_sclk_oe && o_ss_b))
    else $error("block still active after deep stop");
endmodule

bind spx_spi16 spx_spi16_monitor spx_spi16_monitor_inst (
  .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_wait(i_wait), .i_stop3(i_stop3), .i_stop_deep(i_stop_deep), .o_sclk(o_sclk),
  .o_sclk_oe(o_sclk_oe), .o_miso_oe(o_miso_oe), .i_ss_b(i_ss_b), .o_ss_b(o_ss_b),
  .o_ss_oe(o_ss_oe));

// >>> tb/spx_slave_model.sv
module spx_slave_model (
  input wire logic i_clk,
  input wire logic i_sel_b,
  input wire logic i_sclk,
  input wire logic i_mosi,
  input wire logic [15:0] i_preload,
  output logic o_miso,
  output logic [15:0] o_got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] sh_r;
  logic idle_r;

  initial begin
    idle_r = 1'b0;
    o_got = 16'h0000;
    sh_r = 16'h0000;
  end
  // a new word is armed when the master selects us
  always @(negedge i_sel_b) sh_r <= i_preload;
  // mode 0: sample on the leading edge, shift out on the trailing edge
  always @(posedge i_sclk) if (!i_sel_b) o_got <= {o_got[14:0], i_mosi};
  always @(negedge i_sclk) if (!i_sel_b) sh_r <= {sh_r[14:0], 1'b0};
  // released line toggles so a stale level never passes for data
  always @(posedge i_clk) idle_r <= ~idle_r;
  assign o_miso = i_sel_b ? idle_r : sh_r[15];
endmodule

// >>> tb/spx_spi16_tb_top.sv
module spx_spi16_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_b, wr, rd, cpu_wait, stop3, stop_deep, ss_drv_b;
  logic tog_r = 1'b0, sclk_d = 1'b0, sclk_drv = 1'b0, mosi_drv = 1'b0;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, st;
  logic [15:0] pre_v, got, d;
  logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o_b, ss_oe, irq, slv_miso;
  int error_cnt, n_tests, cyc, per;
  // pin levels from every party's enable; released mosi toggles unless the bench selects
  wire sclk_w = sclk_oe ? sclk_o : sclk_drv;
  wire mosi_w = mosi_oe ? mosi_o : (ss_drv_b ? tog_r : mosi_drv);
  wire miso_w = miso_oe ? miso_o : slv_miso;
  wire ss_w = ss_oe ? ss_o_b : ss_drv_b;

  spx_spi16 spx_spi16_inst (.i_clk(clk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_wait(cpu_wait), .i_stop3(stop3),
    .i_stop_deep(stop_deep), .o_irq(irq), .i_sclk(sclk_w), .o_sclk(sclk_o),
    .o_sclk_oe(sclk_oe), .i_mosi(mosi_w), .o_mosi(mosi_o), .o_mosi_oe(mosi_oe),
    .i_miso(miso_w), .o_miso(miso_o), .o_miso_oe(miso_oe), .i_ss_b(ss_w),
    .o_ss_b(ss_o_b), .o_ss_oe(ss_oe));
  spx_slave_model spx_slave_model_inst (.i_clk(clk), .i_sel_b(ss_w), .i_sclk(sclk_w),
    .i_mosi(mosi_w), .i_preload(pre_v), .o_miso(slv_miso), .o_got(got));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // period of the serial clock in bus cycles, rising edge to rising edge
  always @(posedge clk) begin
    sclk_d <= sclk_o;
    tog_r <= ~tog_r;
    if (sclk_o && !sclk_d) begin
      per <= cyc;
      cyc <= 1;
    end else cyc <= cyc + 1;
  end

  task automatic wr8(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd8(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // word as an msb-first partner sees it on the wire
  function automatic logic [15:0] fx(input logic [15:0] v, input logic w16, input logic lsb);
    logic [15:0] r;
    for (int k = 0; k < 16; k++) r[k] = v[15-k];
    if (!lsb) return w16 ? v : {8'h00, v[7:0]};
    return w16 ? r : {8'h00, r[15:8]};
  endfunction

  // hk: 0 plain, 1 wait with stop bit, 2 stop3, 3 wait with stop bit clear
  task automatic run(input logic [7:0] rt, c1, c2, input logic [15:0] tx, rxp, input int hk);
    logic [15:0] er;
    er = fx(c2[6] ? rxp : {8'h00, rxp[15:8]}, c2[6], c1[0]);
    pre_v = rxp;
    wr8(spx_pkg::SPX_OFS_RATE, rt);
    wr8(spx_pkg::SPX_OFS_CTRL2, c2);
    wr8(spx_pkg::SPX_OFS_CTRL1, c1);
    wr8(spx_pkg::SPX_OFS_MATCH_HI, er[15:8]);
    wr8(spx_pkg::SPX_OFS_MATCH_LO, er[7:0]);
    cpu_wait <= (hk == 3);
    wr8(spx_pkg::SPX_OFS_DATA_HI, tx[15:8]);
    wr8(spx_pkg::SPX_OFS_DATA_LO, tx[7:0]);
    if (hk == 1 || hk == 2) begin
      repeat (5) @(posedge clk);
      cpu_wait <= (hk == 1);
      stop3 <= (hk == 2);
      repeat (40) @(posedge clk);
      cpu_wait <= 1'b0;
      stop3 <= 1'b0;
    end
    st = 8'h00;
    for (int i = 0; i < 200 && !st[7]; i++) rd8(spx_pkg::SPX_OFS_STAT, st);
    if (!st[7]) begin
      error_cnt++;
      end_of_test();
    end
    cpu_wait <= 1'b0;
    chk(16'(st[7:6]), 16'h0003);
    chk(16'(irq), 16'h0001);
    if (hk == 0) chk(16'(per), ({13'h0000, rt[6:4]} + 16'h0001) << ({1'b0, rt[2:0]} + 4'h1));
    chk(c2[6] ? got : {8'h00, got[7:0]}, fx(tx, c2[6], c1[0]));
    rd8(spx_pkg::SPX_OFS_DATA_HI, st);
    d[15:8] = st;
    rd8(spx_pkg::SPX_OFS_DATA_LO, st);
    d[7:0] = st;
    chk(c2[6] ? d : {8'h00, d[7:0]}, er);
    wr8(spx_pkg::SPX_OFS_STAT, 8'h40);
  endtask

  initial begin
    {rst_b, wr, rd, addr, wdata, cpu_wait, stop3, stop_deep} = '0;
    {ss_drv_b, pre_v, st, error_cnt, n_tests} = '0;
    ss_drv_b = 1'b1;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    rd8(spx_pkg::SPX_OFS_CTRL1, st);
    chk(16'(st), 16'(spx_pkg::SPX_CTRL1_RST));
    rd8(spx_pkg::SPX_OFS_STAT, st);
    chk(16'(st), 16'h0020);
    wr8(spx_pkg::SPX_OFS_CTRL2, 8'hff);
    rd8(spx_pkg::SPX_OFS_CTRL2, st);
    chk(16'(st), 16'h00db);
    wr8(spx_pkg::SPX_OFS_RATE, 8'hff);
    rd8(spx_pkg::SPX_OFS_RATE, st);
    chk(16'(st), 16'h0077);
    wr8(spx_pkg::SPX_OFS_CTRL1, 8'h50);
    run(8'h10, 8'h52, 8'h90, 16'h00a5, 16'h3c00, 0);
    run(8'h21, 8'h53, 8'hd0, 16'h1234, 16'h8e71, 0);
    run(8'h00, 8'h52, 8'hd2, 16'hbeef, 16'h0f5a, 1);
    run(8'h00, 8'h53, 8'h90, 16'h0081, 16'hc300, 2);
    run(8'h00, 8'h52, 8'hd0, 16'h5555, 16'haaaa, 3);
    // single-wire master with its output on reads its own word back from the shared pin
    wr8(spx_pkg::SPX_OFS_CTRL2, 8'h19);
    wr8(spx_pkg::SPX_OFS_DATA_LO, 8'h6b);
    repeat (40) @(posedge clk);
    chk(16'({mosi_oe, miso_oe}), 16'h0002);
    rd8(spx_pkg::SPX_OFS_DATA_LO, st);
    chk(16'(st), 16'h006b);
    // slave in wait with the stop bit set still shifts on the bench's pin clock
    wr8(spx_pkg::SPX_OFS_CTRL2, 8'h02);
    wr8(spx_pkg::SPX_OFS_CTRL1, 8'h40);
    wr8(spx_pkg::SPX_OFS_DATA_LO, 8'h3a);
    pre_v = 16'h0096;
    cpu_wait <= 1'b1;
    ss_drv_b <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_drv <= pre_v[i];
      repeat (2) @(posedge clk);
      d[i] = miso_w;
      sclk_drv <= 1'b1;
      repeat (2) @(posedge clk);
      sclk_drv <= 1'b0;
    end
    repeat (2) @(posedge clk);
    ss_drv_b <= 1'b1;
    cpu_wait <= 1'b0;
    chk(16'(d[7:0]), 16'h003a);
    rd8(spx_pkg::SPX_OFS_DATA_LO, st);
    chk(16'(st), 16'h0096);
    // select pulled low under a master with fault detection on
    wr8(spx_pkg::SPX_OFS_CTRL2, 8'h10);
    wr8(spx_pkg::SPX_OFS_CTRL1, 8'hd0);
    ss_drv_b <= 1'b0;
    repeat (4) @(posedge clk);
    ss_drv_b <= 1'b1;
    rd8(spx_pkg::SPX_OFS_STAT, st);
    chk(16'(st[4]), 16'h0001);
    chk(16'(irq), 16'h0001);
    stop_deep <= 1'b1;
    @(posedge clk);
    stop_deep <= 1'b0;
    rd8(spx_pkg::SPX_OFS_STAT, st);
    chk(16'(st[4]), 16'h0000);
    rd8(spx_pkg::SPX_OFS_CTRL1, st);
    chk(16'(st), 16'(spx_pkg::SPX_CTRL1_RST));
    end_of_test();
  end
endmodule
